// ===== design/ntsr_pkg.sv
// Package for the target status and transmit length register bank.
// Assumes an 8-bit register port with one-cycle read latency.
package ntsr_pkg;
	// Register addresses
	localparam logic [7:0] ADDR_TARGET_STATE = 8'h21;
	localparam logic [7:0] ADDR_TX_LEN_HIGH  = 8'h22;
	localparam logic [7:0] ADDR_TX_LEN_LOW   = 8'h23;
	localparam logic [7:0] ADDR_RATE_TIMER   = 8'h24;
	localparam logic [7:0] ADDR_CONV_RESULT  = 8'h25;
	// Reset values
	localparam logic [7:0] TX_LEN_HIGH_RST = 8'h00;
	localparam logic [7:0] TX_LEN_LOW_RST  = 8'h00;
	// Field positions
	localparam int RESID_LSB     = 0;
	localparam int RESID_W       = 3;
	localparam int LOWCNT_LSB    = 3;
	localparam int RATE_LSB      = 4;
	localparam int TIMER_FON_POS = 3;
	localparam int TIMER_GPT_POS = 2;
	localparam int TIMER_NRT_POS = 1;
	localparam int TIMER_MRT_POS = 0;
	localparam logic [12:0] TX_BYTES_MAX = 13'h1fff;
	// Target state codes
	typedef enum logic [3:0] {
		ST_POWER_OFF = 4'b0000,
		ST_IDLE      = 4'b0001,
		ST_READY_L1  = 4'b0010,
		ST_READY_L2  = 4'b0011,
		ST_ACTIVE    = 4'b0101,
		ST_HALT      = 4'b1001,
		ST_READY_L1S = 4'b1010,
		ST_READY_L2S = 4'b1011,
		ST_ACTIVE_S  = 4'b1101
	} ntsr_state_t;
endpackage : ntsr_pkg

// ===== design/ntsr_byte_reg.sv
// One 8-bit capture register with a load enable.
// Assumes a single synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module ntsr_byte_reg (
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       rstn,
	// Load
	input  wire logic       load,
	input  wire logic [7:0] din,
	input  wire logic [7:0] rst_val,
	// Held value
	output logic      [7:0] q_ff
);
	// Capture on load, hold otherwise
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			q_ff <= rst_val;
		end else if (load) begin
			q_ff <= din;
		end
	end
endmodule : ntsr_byte_reg
`default_nettype wire

// ===== design/ntsr_regs.sv
// Target status and transmit length register bank.
// Assumes host strobes synchronous to ref_clk, one at a time, and
// core status inputs synchronous to ref_clk.
// Notes on behaviour
// - Target state is shown as a 4-bit code in the low bits of the state register.
// - A 13-bit full-byte count is held, high eight bits in one register, low five in bits 7..3 of the next.
// - Bits 2..0 of the second length register count extra bits after the last byte; zero means whole bytes.
// - Residual bits are sent starting from the least significant bit.
// - Residual bits apply to bit-oriented anticollision frames with a split last byte.
// - In type A mode, a frame with residual bits is sent without parity generation.
// - Anticollision on, card idle and residual count nonzero raise parity error on a REQA or WUPA command.
// - Short frames work only for type A or B started with transmit-without-CRC.
// - Bits 5..4 show the detected bit rate in rate-detection target mode.
// - Timer running flags sit at bits 3..0: field-on wait, general, no-response, mask-receive.
// - The last completed conversion result is held until the next replaces it.
`timescale 1ns/1ps
`default_nettype none
module ntsr_regs (
	// Clock and reset
	input  wire logic                 ref_clk,
	input  wire logic                 rstn,
	// Register port
	input  wire logic [7:0]           addr,
	input  wire logic [7:0]           wdata,
	input  wire logic                 wr_stb,
	input  wire logic                 rd_stb,
	output logic      [7:0]           rdata_ff,
	// Core status
	input  wire ntsr_pkg::ntsr_state_t target_state,
	input  wire logic [1:0]           detected_rate,
	input  wire logic                 rate_detect_mode,
	input  wire logic                 field_on_wait_timer_running,
	input  wire logic                 gp_timer_running,
	input  wire logic                 no_resp_timer_running,
	input  wire logic                 mask_rx_timer_running,
	input  wire logic [7:0]           conv_data,
	input  wire logic                 conv_done,
	// Transmit control
	input  wire logic                 iso_a_mode,
	input  wire logic                 iso_b_mode,
	input  wire logic                 tx_no_crc_cmd,
	input  wire logic                 reqa_wupa_cmd,
	input  wire logic                 anticollision_enable,
	output logic      [12:0]          tx_bytes_ff,
	output logic      [2:0]           tx_resid_bits_ff,
	output logic                      tx_parity_off_ff,
	output logic                      tx_lsb_first_ff,
	output logic                      tx_short_ok_ff,
	output logic                      host_handles_cmds_ff,
	output logic                      parity_err_ff
);
	import ntsr_pkg::*;

	typedef struct packed {
		logic [7:0]  rdata;
		logic [12:0] tx_bytes;
		logic [2:0]  resid;
		logic        par_off;
		logic        lsb_first;
		logic        short_ok;
		logic        host_cmds;
		logic        par_err;
		logic [1:0]  rate;
	} ntsr_st_t;

	ntsr_st_t   st_ff;
	ntsr_st_t   nxt_st;
	logic [7:0] conv_ff;
	logic [7:0] len_high;
	logic [7:0] len_low;

	// Conversion result capture, held until the next completion
	ntsr_byte_reg u_conv (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.load    (conv_done),
		.din     (conv_data),
		.rst_val (8'h00),
		.q_ff    (conv_ff)
	);

	// Length registers as bytes for readback
	assign len_high = st_ff.tx_bytes[12:5];
	assign len_low  = {st_ff.tx_bytes[4:0], st_ff.resid};

	// Next state
	always_comb begin
		nxt_st = st_ff;
		nxt_st.rdata = 8'h00;
		// Writes reach only the length pair; other addresses ignore them
		if (wr_stb && addr == ADDR_TX_LEN_HIGH) begin
			nxt_st.tx_bytes[12:5] = wdata;
		end else if (wr_stb && addr == ADDR_TX_LEN_LOW) begin
			nxt_st.tx_bytes[4:0] = wdata[7:LOWCNT_LSB];
			nxt_st.resid = wdata[RESID_W-1:RESID_LSB];
		end
		// Rate field is refreshed only in rate-detection mode
		if (rate_detect_mode) begin
			nxt_st.rate = detected_rate;
		end
		// Read decode, reserved bits zero
		if (rd_stb && addr == ADDR_TARGET_STATE) begin
			nxt_st.rdata = {4'h0, target_state};
		end else if (rd_stb && addr == ADDR_TX_LEN_HIGH) begin
			nxt_st.rdata = len_high;
		end else if (rd_stb && addr == ADDR_TX_LEN_LOW) begin
			nxt_st.rdata = len_low;
		end else if (rd_stb && addr == ADDR_RATE_TIMER) begin
			nxt_st.rdata = {2'b00, st_ff.rate, field_on_wait_timer_running, gp_timer_running,
				no_resp_timer_running, mask_rx_timer_running};
		end else if (rd_stb && addr == ADDR_CONV_RESULT) begin
			nxt_st.rdata = conv_ff;
		end
		// Residual framing: LSB first, no parity only in type A, anticollision parity error
		nxt_st.lsb_first = (st_ff.resid != 3'b000);
		nxt_st.par_off = iso_a_mode && (st_ff.resid != 3'b000);
		nxt_st.short_ok = (iso_a_mode || iso_b_mode) && tx_no_crc_cmd;
		nxt_st.host_cmds = (target_state == ST_ACTIVE) || (target_state == ST_ACTIVE_S);
		nxt_st.par_err = anticollision_enable && (target_state == ST_IDLE)
			&& (st_ff.resid != 3'b000) && reqa_wupa_cmd;
	end

	// State register
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			st_ff <= '0;
			st_ff.tx_bytes <= {TX_LEN_HIGH_RST, TX_LEN_LOW_RST[7:3]};
			st_ff.resid <= TX_LEN_LOW_RST[2:0];
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Outputs
	assign rdata_ff             = st_ff.rdata;
	assign tx_bytes_ff          = st_ff.tx_bytes;
	assign tx_resid_bits_ff     = st_ff.resid;
	assign tx_parity_off_ff     = st_ff.par_off;
	assign tx_lsb_first_ff      = st_ff.lsb_first;
	assign tx_short_ok_ff       = st_ff.short_ok;
	assign host_handles_cmds_ff = st_ff.host_cmds;
	assign parity_err_ff        = st_ff.par_err;

	// Checks
	a_len_high_write: assert property (@(posedge ref_clk) disable iff (!rstn)
		wr_stb && addr == ADDR_TX_LEN_HIGH |=> tx_bytes_ff[12:5] == $past(wdata))
		else $error("length high write lost");
	a_len_low_write: assert property (@(posedge ref_clk) disable iff (!rstn)
		wr_stb && addr == ADDR_TX_LEN_LOW |=> tx_bytes_ff[4:0] == $past(wdata[7:3]))
		else $error("length low write lost");
	a_resid_write: assert property (@(posedge ref_clk) disable iff (!rstn)
		wr_stb && addr == ADDR_TX_LEN_LOW |=> tx_resid_bits_ff == $past(wdata[2:0]))
		else $error("residual count write lost");
	a_state_read: assert property (@(posedge ref_clk) disable iff (!rstn)
		rd_stb && addr == ADDR_TARGET_STATE |=> rdata_ff == {4'h0, $past(target_state)})
		else $error("state read wrong");
	a_timer_read: assert property (@(posedge ref_clk) disable iff (!rstn)
		rd_stb && addr == ADDR_RATE_TIMER |=> rdata_ff[7:6] == 2'b00
		&& rdata_ff[3] == $past(field_on_wait_timer_running))
		else $error("timer flags wrong");
	a_conv_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
		conv_done ##1 !conv_done ##1 (rd_stb && addr == ADDR_CONV_RESULT && !conv_done)
		|=> rdata_ff == $past(conv_data, 3))
		else $error("conversion result wrong");
	a_parity_off: assert property (@(posedge ref_clk) disable iff (!rstn)
		iso_a_mode && tx_resid_bits_ff != 3'b000 |=> tx_parity_off_ff)
		else $error("parity not off");
	a_parity_err: assert property (@(posedge ref_clk) disable iff (!rstn)
		anticollision_enable && target_state == ST_IDLE && tx_resid_bits_ff != 3'b000
		&& reqa_wupa_cmd |=> parity_err_ff)
		else $error("parity error missed");
	a_host_cmds: assert property (@(posedge ref_clk) disable iff (!rstn)
		target_state == ST_ACTIVE_S |=> host_handles_cmds_ff)
		else $error("host command flag missed");
	a_short_frame: assert property (@(posedge ref_clk) disable iff (!rstn)
		!tx_no_crc_cmd |=> !tx_short_ok_ff)
		else $error("short frame without no-crc command");
	a_ro_write: assert property (@(posedge ref_clk) disable iff (!rstn)
		wr_stb && addr == ADDR_CONV_RESULT |=> $stable(tx_bytes_ff))
		else $error("read-only write had effect");
	a_lsb_first: assert property (@(posedge ref_clk) disable iff (!rstn)
		tx_resid_bits_ff != 3'b000 |=> tx_lsb_first_ff)
		else $error("lsb first missed");
	a_rate_field: assert property (@(posedge ref_clk) disable iff (!rstn)
		rate_detect_mode ##1 !rate_detect_mode ##1 (rd_stb && addr == ADDR_RATE_TIMER && !rate_detect_mode)
		|=> rdata_ff[5:4] == $past(detected_rate, 3))
		else $error("rate field wrong");
	c_resid_frame: cover property (@(posedge ref_clk) disable iff (!rstn) tx_parity_off_ff);
	c_par_err: cover property (@(posedge ref_clk) disable iff (!rstn) parity_err_ff);
	c_conv_read: cover property (@(posedge ref_clk) disable iff (!rstn)
		conv_done ##2 rd_stb && addr == ADDR_CONV_RESULT);
	c_len_write: cover property (@(posedge ref_clk) disable iff (!rstn)
		wr_stb && addr == ADDR_TX_LEN_LOW ##1 rd_stb && addr == ADDR_TX_LEN_LOW);
endmodule : ntsr_regs
`default_nettype wire

// ===== tb/ntsr_regs_bench.sv
// Self-checking bench for the target status and transmit length register bank.
// Assumes read data one cycle after rd_stb; the bank's own assertions sit in its design files.
`timescale 1ns/1ps
`default_nettype none
module ntsr_regs_bench;
	import ntsr_pkg::*;
	// Stimulus and observed signals
	logic        ref_clk = 1'b0, rstn = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0;
	logic [7:0]  addr = 8'h00, wdata = 8'h00, conv_data = 8'h00, rdata_ff;
	logic [3:0]  tmr = 4'h0;
	logic [1:0]  detected_rate = 2'h0;
	logic        rate_mode = 1'b0, conv_done = 1'b0, iso_a = 1'b1, iso_b = 1'b0, no_crc = 1'b0;
	logic        reqa = 1'b0, anticoll = 1'b1, par_off, lsb_first, short_ok, host_cmds, par_err;
	logic [12:0] tx_bytes_ff;
	logic [2:0]  tx_resid;
	ntsr_state_t target_state = ST_IDLE;
	int          err_count = 0;
	int          n_tests = 0;

	ntsr_regs DUT (.ref_clk(ref_clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
		.rd_stb(rd_stb), .rdata_ff(rdata_ff), .target_state(target_state), .detected_rate(detected_rate),
		.rate_detect_mode(rate_mode), .field_on_wait_timer_running(tmr[3]), .gp_timer_running(tmr[2]),
		.no_resp_timer_running(tmr[1]), .mask_rx_timer_running(tmr[0]), .conv_data(conv_data),
		.conv_done(conv_done), .iso_a_mode(iso_a), .iso_b_mode(iso_b), .tx_no_crc_cmd(no_crc),
		.reqa_wupa_cmd(reqa), .anticollision_enable(anticoll), .tx_bytes_ff(tx_bytes_ff),
		.tx_resid_bits_ff(tx_resid), .tx_parity_off_ff(par_off), .tx_lsb_first_ff(lsb_first),
		.tx_short_ok_ff(short_ok), .host_handles_cmds_ff(host_cmds), .parity_err_ff(par_err));

	// Clock at 25 MHz
	always #20 ref_clk = ~ref_clk;

	// Compare and count
	task automatic chk(input string what, input logic [12:0] exp, input logic [12:0] got);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// One strobe cycle launched at a rising edge
	task automatic op(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		wr_stb <= w;
		rd_stb <= ~w;
		addr   <= a;
		wdata  <= d;
	endtask : op

	// Drop strobes; returns just after the edge that took the last one
	task automatic idle;
		@(posedge ref_clk);
		wr_stb <= 1'b0;
		rd_stb <= 1'b0;
		#1;
	endtask : idle

	// Read and compare the answer in its single valid cycle
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		op(1'b0, a, 8'h00);
		idle();
		chk(what, {5'h0, exp}, {5'h0, rdata_ff});
	endtask : rd

	// Pulse the REQA/WUPA command and watch the one-cycle error pulse
	task automatic pulse_reqa(input logic exp);
		@(posedge ref_clk);
		reqa <= 1'b1;
		@(posedge ref_clk);
		reqa <= 1'b0;
		#1;
		chk("parity_err", {12'h0, exp}, {12'h0, par_err});
		@(posedge ref_clk);
		#1;
		chk("parity_err_end", 13'h0, {12'h0, par_err});
	endtask : pulse_reqa

	// Verdict and end of run
	task automatic final_report;
		$display("Comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : final_report

	// Main sequence
	initial begin
		ntsr_state_t s;
		repeat (8) @(posedge ref_clk);
		rstn <= 1'b1;
		rd(ADDR_TX_LEN_HIGH, TX_LEN_HIGH_RST, "len_high_rst");
		rd(ADDR_TX_LEN_LOW, TX_LEN_LOW_RST, "len_low_rst");
		// Largest count plus five residual bits, written back to back
		op(1'b1, ADDR_TX_LEN_HIGH, 8'hff);
		op(1'b1, ADDR_TX_LEN_LOW, 8'hfd);
		idle();
		chk("tx_bytes", TX_BYTES_MAX, tx_bytes_ff);
		chk("tx_resid", 13'h5, {10'h0, tx_resid});
		rd(ADDR_TX_LEN_LOW, 8'hfd, "len_low");
		chk("parity_off", 13'h1, {12'h0, par_off});
		chk("lsb_first", 13'h1, {12'h0, lsb_first});
		pulse_reqa(1'b1);
		// Whole bytes only: no split byte, parity back on, no error pulse
		op(1'b1, ADDR_TX_LEN_LOW, 8'h08);
		idle();
		@(posedge ref_clk);
		#1;
		chk("tx_bytes_low", 13'h1fe1, tx_bytes_ff);
		chk("parity_on", 13'h0, {12'h0, par_off});
		chk("lsb_off", 13'h0, {12'h0, lsb_first});
		pulse_reqa(1'b0);
		// Short frames only for type A or B with the no-CRC command
		for (int i = 0; i < 8; i++) begin
			@(posedge ref_clk);
			{iso_a, iso_b, no_crc} <= i[2:0];
			@(posedge ref_clk);
			#1;
			chk("short_ok", {12'h0, (i[2] | i[1]) & i[0]}, {12'h0, short_ok});
		end
		// Every state code reads back, host takes over in the active states
		s = s.first();
		do begin
			@(posedge ref_clk);
			target_state <= s;
			rd(ADDR_TARGET_STATE, {4'h0, s}, "target_state");
			chk("host_cmds", {12'h0, s == ST_ACTIVE || s == ST_ACTIVE_S}, {12'h0, host_cmds});
			s = s.next();
		end while (s != s.first());
		// Rate field and each timer flag alone
		@(posedge ref_clk);
		rate_mode     <= 1'b1;
		detected_rate <= 2'h2;
		for (int i = 0; i < 4; i++) begin
			@(posedge ref_clk);
			tmr <= 4'h1 << i;
			rd(ADDR_RATE_TIMER, 8'h20 | (8'h01 << i), "rate_timer");
		end
		@(posedge ref_clk);
		rate_mode     <= 1'b0;
		detected_rate <= 2'h1;
		tmr           <= 4'h0;
		rd(ADDR_RATE_TIMER, 8'h20, "rate_held");
		// Conversion result held until the next one lands
		for (int i = 0; i < 2; i++) begin
			@(posedge ref_clk);
			conv_data <= i ? 8'h3c : 8'ha5;
			conv_done <= 1'b1;
			@(posedge ref_clk);
			conv_done <= 1'b0;
			conv_data <= 8'h00;
			rd(ADDR_CONV_RESULT, i ? 8'h3c : 8'ha5, "conv_result");
		end
		// Writes to read-only and unmapped places change nothing
		op(1'b1, ADDR_TARGET_STATE, 8'hff);
		op(1'b1, ADDR_RATE_TIMER, 8'hff);
		op(1'b1, ADDR_CONV_RESULT, 8'hff);
		op(1'b1, 8'h30, 8'hff);
		idle();
		rd(ADDR_CONV_RESULT, 8'h3c, "conv_ro");
		rd(ADDR_RATE_TIMER, 8'h20, "rate_ro");
		rd(8'h30, 8'h00, "unmapped");
		chk("tx_bytes_kept", 13'h1fe1, tx_bytes_ff);
		final_report();
	end

	// Watchdog against a hang
	initial begin
		repeat (5000) @(posedge ref_clk);
		err_count++;
		$display("FAIL watchdog expected end seen timeout");
		final_report();
	end
endmodule : ntsr_regs_bench
`default_nettype wire
